// ===== verilog/uart_pkg.sv
// Summary of operation
// - reset loads baud control with 1fh
// - select timer output, clock/2, /8, /32
// - divider k from 8 to 31 divides base
// - bit rate is base clock over 2k
// - timer output reaches selector without pin enable
// - direction bit 0 drives pin; resets ffh
// - power off stops clock, clears serial state
// - power off forces receive input high
// - clearing an enable resets that circuit
// - all three bits clear: stop, pins ordinary
// - transmit enable sets pin 0 output to serial output ANDed with latch bit 0; drive still needs direction bit 0 clear
// - start-bit framed characters, full duplex
// - mode register resets to 01h, bit0 one
// - parity codes none, zero, odd, even
// - character length seven or eight bits
// - one or two transmit stops, receive one
package uart_pkg;
    localparam int unsigned ADDR_W = 20;
    localparam logic [17:0] IDX_MODE = 18'h0ff70;
    localparam logic [17:0] IDX_BAUD = 18'h0ff71;
    localparam logic [17:0] IDX_DIR = 18'h0ff72;
    localparam logic [17:0] IDX_ERR = 18'h0ff73;
    localparam logic [17:0] IDX_TXD = 18'h0ff74;
    localparam logic [17:0] IDX_RXD = 18'h0ff75;
    localparam logic [17:0] IDX_LATCH = 18'h0ff76;
    localparam logic [17:0] IDX_FLAGS = 18'h0ff77;
    localparam logic [7:0] MODE_RST = 8'h01;
    localparam logic [7:0] MODE_FIXED = 8'h01;
    localparam logic [7:0] BAUD_RST = 8'h1f;
    localparam logic [7:0] BAUD_MASK = 8'hdf;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam int unsigned MODE_POWER = 7;
    localparam int unsigned MODE_TXE = 6;
    localparam int unsigned MODE_RXE = 5;
    localparam int unsigned MODE_CL = 2;
    localparam int unsigned MODE_SL = 1;
    localparam int unsigned TX_PIN = 0;
    localparam int unsigned RX_PIN = 1;
    localparam int unsigned ERR_PARITY = 2;
    localparam int unsigned ERR_FRAME = 1;
    localparam int unsigned ERR_OVERRUN = 0;
    localparam logic [1:0] SEL_TIMER = 2'h0;
    localparam logic [1:0] SEL_DIV2 = 2'h1;
    localparam logic [1:0] SEL_DIV8 = 2'h2;
    localparam logic [1:0] SEL_DIV32 = 2'h3;
    localparam logic [4:0] PRE_MASK2 = 5'h01;
    localparam logic [4:0] PRE_MASK8 = 5'h07;
    localparam logic [4:0] PRE_MASK32 = 5'h1f;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    localparam logic [2:0] LAST_BIT7 = 3'h6;
    localparam logic [2:0] LAST_BIT8 = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3,
        TX_PAR = 3'h2, TX_STOP1 = 3'h6, TX_STOP2 = 3'h7
    } tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
        RX_PAR = 3'h2, RX_STOP = 3'h6
    } rx_state_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] baud;
        logic [7:0] dir;
        logic [7:0] latch;
        logic [2:0] err;
        logic [7:0] rxbuf;
        logic rx_full;
        logic [4:0] pre;
        logic tmr_prev;
        tx_state_t tx_st;
        logic [5:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic tx_line;
        rx_state_t rx_st;
        logic [5:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_par;
        logic rx_prev;
        logic aw_got;
        logic [ADDR_W-1:0] awaddr;
        logic w_got;
        logic [7:0] wdata;
        logic wstrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [7:0] p1_out;
        logic [7:0] p1_oe_n;
    } state_t;
endpackage : uart_pkg

// ===== verilog/uart_ctrl.sv
module uart_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [uart_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [uart_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic timer_a_output,
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe_n
);
    uart_pkg::state_t q;
    uart_pkg::state_t d;
    logic pwr;
    logic txe;
    logic rxe;
    logic base_tick;
    logic [4:0] k;
    logic [5:0] bit_last;
    logic [5:0] half_last;
    logic [2:0] n_last;
    logic [1:0] ps;
    logic rx_in;
    logic do_write;
    logic [17:0] widx;
    logic [17:0] ridx;
    logic tx_start;
    logic data_par;
    logic rx_fire;

    // next-state logic for the whole block
    always_comb begin
        d = q;
        pwr = q.mode[uart_pkg::MODE_POWER];
        txe = pwr & q.mode[uart_pkg::MODE_TXE];
        rxe = pwr & q.mode[uart_pkg::MODE_RXE];
        k = q.baud[4:0];
        ps = q.mode[4:3];
        bit_last = {k, 1'b0} - 6'h01;
        half_last = {1'b0, k} - 6'h01;
        n_last = q.mode[uart_pkg::MODE_CL] ? uart_pkg::LAST_BIT8 : uart_pkg::LAST_BIT7;
        rx_in = pwr ? p1_in[uart_pkg::RX_PIN] : 1'b1;
        d.rx_prev = rx_in;
        tx_start = 1'b0;
        rx_fire = 1'b0;
        widx = q.awaddr[uart_pkg::ADDR_W-1:2];
        ridx = araddr[uart_pkg::ADDR_W-1:2];
        data_par = q.mode[uart_pkg::MODE_CL] ? ^q.wdata : ^q.wdata[6:0];

        // prescaler, idle while power is off
        d.pre = pwr ? q.pre + 5'h01 : 5'h00;
        d.tmr_prev = timer_a_output;
        case (q.baud[7:6])
            uart_pkg::SEL_TIMER: base_tick = timer_a_output & ~q.tmr_prev;
            uart_pkg::SEL_DIV2: base_tick = (q.pre & uart_pkg::PRE_MASK2) == uart_pkg::PRE_MASK2;
            uart_pkg::SEL_DIV8: base_tick = (q.pre & uart_pkg::PRE_MASK8) == uart_pkg::PRE_MASK8;
            default: base_tick = q.pre == uart_pkg::PRE_MASK32;
        endcase
        base_tick = base_tick & pwr;

        // write address and data, taken in either order
        if (awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = awaddr;
        end
        if (wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = wdata[7:0];
            d.wstrb0 = wstrb[0];
        end
        if (bready && q.bvalid) begin
            d.bvalid = 1'b0;
        end
        do_write = q.aw_got && q.w_got && !q.bvalid;
        if (do_write) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = uart_pkg::RESP_OKAY;
            case (widx)
                uart_pkg::IDX_MODE: begin
                    if (q.wstrb0) d.mode = q.wdata | uart_pkg::MODE_FIXED;
                end
                uart_pkg::IDX_BAUD: begin
                    if (q.wstrb0) d.baud = q.wdata & uart_pkg::BAUD_MASK;
                end
                uart_pkg::IDX_DIR: begin
                    if (q.wstrb0) d.dir = q.wdata;
                end
                uart_pkg::IDX_LATCH: begin
                    if (q.wstrb0) d.latch = q.wdata;
                end
                uart_pkg::IDX_TXD: begin
                    tx_start = q.wstrb0 && txe && q.tx_st == uart_pkg::TX_IDLE;
                end
                uart_pkg::IDX_ERR, uart_pkg::IDX_RXD, uart_pkg::IDX_FLAGS: begin
                    d.bresp = uart_pkg::RESP_OKAY;
                end
                default: d.bresp = uart_pkg::RESP_SLVERR;
            endcase
        end

        // read channel; reads of status and buffer have side effects
        if (rready && q.rvalid) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = uart_pkg::RESP_OKAY;
            d.rdata = 8'h00;
            case (ridx)
                uart_pkg::IDX_MODE: d.rdata = q.mode;
                uart_pkg::IDX_BAUD: d.rdata = q.baud;
                uart_pkg::IDX_DIR: d.rdata = q.dir;
                uart_pkg::IDX_LATCH: d.rdata = q.latch;
                uart_pkg::IDX_TXD: d.rdata = q.tx_sh;
                uart_pkg::IDX_ERR: begin
                    d.rdata = {5'h00, q.err};
                    d.err = 3'h0;
                end
                uart_pkg::IDX_RXD: begin
                    d.rdata = q.rxbuf;
                    d.rx_full = 1'b0;
                end
                uart_pkg::IDX_FLAGS: d.rdata = {6'h00, q.rx_full, q.tx_st != uart_pkg::TX_IDLE};
                default: d.rresp = uart_pkg::RESP_SLVERR;
            endcase
        end

        // transmitter, held idle while disabled
        if (!txe) begin
            d.tx_st = uart_pkg::TX_IDLE;
            d.tx_cnt = 6'h00;
            d.tx_line = 1'b1;
        end else if (q.tx_st == uart_pkg::TX_IDLE) begin
            if (tx_start) begin
                d.tx_sh = q.wdata;
                d.tx_par = (ps == uart_pkg::PAR_ODD) ? ~data_par :
                           (ps == uart_pkg::PAR_EVEN) ? data_par : 1'b0;
                d.tx_st = uart_pkg::TX_START;
                d.tx_cnt = 6'h00;
                d.tx_line = 1'b0;
            end
        end else if (base_tick) begin
            d.tx_cnt = q.tx_cnt + 6'h01;
            if (q.tx_cnt == bit_last) begin
                d.tx_cnt = 6'h00;
                case (q.tx_st)
                    uart_pkg::TX_START: begin
                        d.tx_st = uart_pkg::TX_DATA;
                        d.tx_bit = 3'h0;
                        d.tx_line = q.tx_sh[0];
                    end
                    uart_pkg::TX_DATA: begin
                        d.tx_sh = q.tx_sh >> 1;
                        d.tx_bit = q.tx_bit + 3'h1;
                        d.tx_line = q.tx_sh[1];
                        if (q.tx_bit == n_last) begin
                            if (ps == uart_pkg::PAR_NONE) begin
                                d.tx_st = uart_pkg::TX_STOP1;
                                d.tx_line = 1'b1;
                            end else begin
                                d.tx_st = uart_pkg::TX_PAR;
                                d.tx_line = q.tx_par;
                            end
                        end
                    end
                    uart_pkg::TX_PAR: begin
                        d.tx_st = uart_pkg::TX_STOP1;
                        d.tx_line = 1'b1;
                    end
                    uart_pkg::TX_STOP1: begin
                        d.tx_st = q.mode[uart_pkg::MODE_SL] ? uart_pkg::TX_STOP2 :
                                  uart_pkg::TX_IDLE;
                    end
                    default: d.tx_st = uart_pkg::TX_IDLE;
                endcase
            end
        end

        // receiver, held idle while disabled
        if (!rxe) begin
            d.rx_st = uart_pkg::RX_IDLE;
            d.rx_cnt = 6'h00;
        end else if (q.rx_st == uart_pkg::RX_IDLE) begin
            if (q.rx_prev && !rx_in) begin
                d.rx_st = uart_pkg::RX_START;
                d.rx_cnt = 6'h00;
            end
        end else if (base_tick) begin
            d.rx_cnt = q.rx_cnt + 6'h01;
            if (q.rx_st == uart_pkg::RX_START) begin
                if (q.rx_cnt == half_last) begin
                    d.rx_cnt = 6'h00;
                    d.rx_bit = 3'h0;
                    d.rx_par = 1'b0;
                    d.rx_st = rx_in ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
                end
            end else if (q.rx_cnt == bit_last) begin
                d.rx_cnt = 6'h00;
                case (q.rx_st)
                    uart_pkg::RX_DATA: begin
                        d.rx_sh = {rx_in, q.rx_sh[7:1]};
                        d.rx_par = q.rx_par ^ rx_in;
                        d.rx_bit = q.rx_bit + 3'h1;
                        if (q.rx_bit == n_last) begin
                            d.rx_st = (ps == uart_pkg::PAR_NONE) ? uart_pkg::RX_STOP :
                                      uart_pkg::RX_PAR;
                        end
                    end
                    uart_pkg::RX_PAR: begin
                        d.rx_par = q.rx_par ^ rx_in;
                        d.rx_st = uart_pkg::RX_STOP;
                    end
                    default: begin
                        rx_fire = 1'b1;
                        d.rx_st = uart_pkg::RX_IDLE;
                    end
                endcase
            end
        end

        // end of character: flags set over any clear in the same cycle
        if (rx_fire) begin
            if (!rx_in) d.err[uart_pkg::ERR_FRAME] = 1'b1;
            if ((ps == uart_pkg::PAR_ODD && !q.rx_par) ||
                (ps == uart_pkg::PAR_EVEN && q.rx_par)) begin
                d.err[uart_pkg::ERR_PARITY] = 1'b1;
            end
            if (q.rx_full) begin
                d.err[uart_pkg::ERR_OVERRUN] = 1'b1;
            end else begin
                d.rxbuf = q.mode[uart_pkg::MODE_CL] ? q.rx_sh : {1'b0, q.rx_sh[7:1]};
                d.rx_full = 1'b1;
            end
        end

        // power off clears the serial state
        if (!pwr) begin
            d.err = 3'h0;
            d.rxbuf = 8'h00;
            d.rx_full = 1'b0;
            d.tx_sh = 8'h00;
        end

        // bus handshake readiness
        d.awready = !d.aw_got && !d.bvalid;
        d.wready = !d.w_got && !d.bvalid;
        d.arready = !d.rvalid;

        // pins: direction and latch, serial functions when enabled
        d.p1_oe_n = q.dir;
        d.p1_out = q.latch;
        if (txe) begin
            d.p1_out[uart_pkg::TX_PIN] = q.tx_line & q.latch[uart_pkg::TX_PIN];
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.mode <= uart_pkg::MODE_RST;
            q.baud <= uart_pkg::BAUD_RST;
            q.dir <= uart_pkg::DIR_RST;
            q.p1_oe_n <= uart_pkg::DIR_RST;
            q.tx_line <= 1'b1;
            q.rx_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = {24'h000000, q.rdata};
    assign p1_out = q.p1_out;
    assign p1_oe_n = q.p1_oe_n;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_div2_tick;
        pwr && q.baud[7:6] == uart_pkg::SEL_DIV2 && base_tick;
    endsequence
    sequence s_div2_hold;
        pwr && q.baud[7:6] == uart_pkg::SEL_DIV2;
    endsequence
    sequence s_rx_done_free;
        rx_fire && !q.rx_full && pwr;
    endsequence
    sequence s_stop_mode;
        !pwr && !q.mode[uart_pkg::MODE_TXE] && !q.mode[uart_pkg::MODE_RXE];
    endsequence

    AST_BAUD_RESET: assert property ($rose(aresetn) |-> q.baud == 8'h1f)
        else $error("baud control not 1fh after reset");
    AST_MODE_RESET: assert property ($rose(aresetn) |-> q.mode == 8'h01)
        else $error("mode register not 01h after reset");
    AST_MODE_BIT0: assert property (q.mode[0])
        else $error("mode bit 0 cleared");
    AST_DIR_RESET: assert property ($rose(aresetn) |-> p1_oe_n == 8'hff)
        else $error("pins not released after reset");
    AST_PIN_DIR: assert property (##1 p1_oe_n == $past(q.dir))
        else $error("output enable does not follow direction");
    AST_DIV2_RATE: assert property (s_div2_tick ##1 s_div2_hold ##1
        s_div2_hold |-> base_tick)
        else $error("base clock over two missed a tick");
    AST_POWER_OFF_CLEAR: assert property (!pwr |=> q.err == 3'h0 && !q.rx_full)
        else $error("serial state kept while power off");
    AST_POWER_OFF_TICK: assert property (!pwr |-> !base_tick)
        else $error("base clock running with power off");
    AST_TX_DISABLED: assert property (!txe |=> q.tx_st == uart_pkg::TX_IDLE && q.tx_line)
        else $error("transmitter not reset while disabled");
    AST_TX_PIN: assert property (txe |=> p1_out[0] == ($past(q.tx_line) & $past(q.latch[0])))
        else $error("transmit pin not driven by serial output");
    AST_RX_STORE: assert property (s_rx_done_free |=> q.rx_full)
        else $error("received character not stored");
    AST_STOP_PINS: assert property (s_stop_mode |=> p1_out == $past(q.latch))
        else $error("stop mode pins not following the latch");
    AST_TX_START_BIT: assert property (tx_start |=> !q.tx_line &&
        q.tx_st == uart_pkg::TX_START)
        else $error("start bit not launched");
    AST_PRE_HELD: assert property (!pwr |=> q.pre == 5'h00)
        else $error("prescaler running with power off");
    AST_ZERO_PARITY: assert property (q.tx_st == uart_pkg::TX_PAR &&
        ps == uart_pkg::PAR_ZERO |-> !q.tx_line)
        else $error("zero parity bit not low");
endmodule : uart_ctrl

// ===== tb/uart_remote.sv
module uart_remote (
    input wire logic aclk,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;

    // mark level while idle
    initial rxd = 1'b1;

    // one frame: start, data lsb first, optional parity, one stop
    task automatic send(input logic [7:0] d, input int nb, input int bc,
                        input logic [1:0] pm, input logic bp, input logic bs);
        logic p;
        p = (pm[1] & (^(d & (nb == 8 ? 8'hff : 8'h7f)) ^ ~pm[0])) ^ bp;
        @(posedge aclk);
        rxd <= 1'b0;
        repeat (bc) @(posedge aclk);
        for (int i = 0; i < nb; i++) begin
            rxd <= d[i];
            repeat (bc) @(posedge aclk);
        end
        if (pm != 2'h0) begin
            rxd <= p;
            repeat (bc) @(posedge aclk);
        end
        rxd <= ~bs;
        repeat (bc) @(posedge aclk);
        rxd <= 1'b1;
    endtask : send

    // sample a frame mid-bit from the falling start edge
    task automatic recv(output logic [7:0] d, output logic p, output logic s,
                        input int nb, input int bc, input logic hp);
        int n;
        d = 8'h00;
        p = 1'b0;
        n = 0;
        while (txd !== 1'b0 && n < 20000) begin
            @(posedge aclk);
            n++;
        end
        // no start edge seen: unknown stop marks the timeout
        if (n >= 20000) begin
            s = 1'bx;
            return;
        end
        repeat (bc / 2) @(posedge aclk);
        for (int i = 0; i < nb; i++) begin
            repeat (bc) @(posedge aclk);
            d[i] = txd;
        end
        if (hp) begin
            repeat (bc) @(posedge aclk);
            p = txd;
        end
        repeat (bc) @(posedge aclk);
        s = txd;
    endtask : recv
endmodule : uart_remote

// ===== tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [uart_pkg::ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, tmr = 1'b0;
    logic [31:0] wdata = '0;
    logic awready, wready, bvalid, arready, rvalid, rxd, tp, ts, sb;
    logic [1:0] bresp, rresp, rs, pm;
    logic [31:0] rdata, rd;
    logic [7:0] p1_out, p1_oe_n, p1_in, td, mk;
    logic [2:0] tdiv = 3'h0;
    int miscompares = 0, cmp_count = 0, nb;
    // per format: baud setting, mode bits, data, clocks per bit, errors
    logic [7:0] bd [5] = '{8'h48, 8'h49, 8'h88, 8'hc8, 8'h08};
    logic [7:0] fm [5] = '{8'h05, 8'h1d, 8'h13, 8'h0b, 8'h1f};
    logic [7:0] dt [5] = '{8'h87, 8'h55, 8'h36, 8'h5a, 8'ha5};
    int bc [5] = '{32, 36, 128, 512, 96};
    logic [2:0] er [5] = '{3'h2, 3'h0, 3'h4, 3'h0, 3'h0};
    logic bp [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic bs [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

    always #4 aclk = ~aclk;

    // timer output, 50% duty, period six clocks
    always @(posedge aclk) begin
        tdiv <= (tdiv == 3'h2) ? 3'h0 : tdiv + 3'h1;
        if (tdiv == 3'h2) tmr <= ~tmr;
    end

    // undriven pins pulled high, bit 1 from the remote
    assign p1_in = {p1_oe_n[7:2] | p1_out[7:2], rxd, p1_oe_n[0] | p1_out[0]};

    uart_ctrl uart_ctrl_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timer_a_output(tmr), .p1_in(p1_in), .p1_out(p1_out), .p1_oe_n(p1_oe_n));
    uart_remote uart_remote_i (.aclk(aclk), .txd(p1_oe_n[0] | p1_out[0]), .rxd(rxd));

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tmo(input int n);
        if (n >= 2000) begin
            miscompares++;
            $display("mismatch at %0t: bus timeout", $time);
            conclude();
        end
    endtask : tmo

    // bus write, address and data offered together
    task automatic wr(input logic [17:0] idx, input logic [7:0] d);
        int n;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 2000);
        bready <= 1'b0;
        tmo(n);
        rs = bresp;
    endtask : wr

    // bus read
    task automatic rdr(input logic [17:0] idx);
        int n;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 2000);
        rready <= 1'b0;
        tmo(n);
        rd = rdata;
        rs = rresp;
    endtask : rdr

    task automatic rc(input logic [17:0] idx, input logic [31:0] exp);
        rdr(idx);
        chk(rd, exp);
    endtask : rc

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        chk(32'(p1_oe_n), 32'hff);
        rc(uart_pkg::IDX_MODE, 32'h01);
        rc(uart_pkg::IDX_BAUD, 32'h1f);
        rc(uart_pkg::IDX_DIR, 32'hff);
        wr(uart_pkg::IDX_MODE, 8'h00);
        rc(uart_pkg::IDX_MODE, 32'h01);
        wr(18'h0ff80, 8'h00);
        chk(32'(rs), 32'(uart_pkg::RESP_SLVERR));
        rdr(18'h0ff80);
        chk(32'(rs), 32'(uart_pkg::RESP_SLVERR));
        // serial pins: transmit driven with latch high, receive as input
        wr(uart_pkg::IDX_LATCH, 8'h01);
        wr(uart_pkg::IDX_DIR, 8'hfe);
        repeat (3) @(posedge aclk);
        chk(32'(p1_oe_n), 32'hfe);
        // every clock source and parity code, both directions at once
        for (int e = 0; e < 5; e++) begin
            wr(uart_pkg::IDX_MODE, 8'h81);
            repeat (64) @(posedge aclk);
            wr(uart_pkg::IDX_MODE, 8'h01);
            wr(uart_pkg::IDX_BAUD, bd[e]);
            wr(uart_pkg::IDX_MODE, fm[e]);
            wr(uart_pkg::IDX_MODE, fm[e] | 8'h80);
            wr(uart_pkg::IDX_MODE, fm[e] | 8'he0);
            nb = fm[e][2] ? 8 : 7;
            mk = fm[e][2] ? 8'hff : 8'h7f;
            pm = fm[e][4:3];
            fork
                begin
                    uart_remote_i.recv(td, tp, ts, nb, bc[e], pm != 2'h0);
                    if (ts === 1'bx) tmo(2000);
                    repeat (bc[e]) @(posedge aclk);
                    rdr(uart_pkg::IDX_FLAGS);
                    sb = rd[0];
                end
                wr(uart_pkg::IDX_TXD, dt[e]);
                uart_remote_i.send(~dt[e], nb, bc[e], pm, bp[e], bs[e]);
            join
            chk(32'(td), 32'(dt[e] & mk));
            chk(32'(tp), 32'(pm[1] & (^(dt[e] & mk) ^ ~pm[0])));
            chk(32'(ts), 32'h1);
            chk(32'(sb), 32'(fm[e][1]));
            rc(uart_pkg::IDX_ERR, 32'(er[e]));
            rc(uart_pkg::IDX_RXD, 32'(~dt[e] & mk));
        end
        // abort a frame by clearing the transmit enable
        wr(uart_pkg::IDX_TXD, 8'hc3);
        repeat (300) @(posedge aclk);
        wr(uart_pkg::IDX_MODE, 8'h9f);
        rc(uart_pkg::IDX_FLAGS, 32'h0);
        repeat (40) @(posedge aclk);
        // receive, then power down with data pending
        wr(uart_pkg::IDX_MODE, 8'hbf);
        uart_remote_i.send(8'h3c, 8, 96, 2'h3, 1'b0, 1'b0);
        rc(uart_pkg::IDX_FLAGS, 32'h2);
        wr(uart_pkg::IDX_MODE, 8'h9f);
        wr(uart_pkg::IDX_MODE, 8'h1f);
        rc(uart_pkg::IDX_FLAGS, 32'h0);
        rc(uart_pkg::IDX_RXD, 32'h0);
        // receive enable without power hears nothing
        wr(uart_pkg::IDX_MODE, 8'h3f);
        uart_remote_i.send(8'h00, 8, 96, 2'h3, 1'b0, 1'b0);
        rc(uart_pkg::IDX_FLAGS, 32'h0);
        rc(uart_pkg::IDX_ERR, 32'h0);
        // stop mode: pins follow the port latch
        wr(uart_pkg::IDX_MODE, 8'h01);
        wr(uart_pkg::IDX_LATCH, 8'h00);
        repeat (3) @(posedge aclk);
        chk(32'(p1_out), 32'h00);
        conclude();
    end
endmodule : testbench
